// ===== duplex_pkg.sv
package duplex_pkg;

  // clock and slot timing
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned SLOT_BITS = 512;
  localparam int unsigned BIT_NS_100 = 10;
  localparam int unsigned BIT_NS_10 = 100;
  localparam int unsigned SLOT100_CYCLES =
    SLOT_BITS * BIT_NS_100 / CLK_PERIOD_NS;
  localparam int unsigned SLOT10_CYCLES =
    SLOT_BITS * BIT_NS_10 / CLK_PERIOD_NS;
  // cycles between two link pulse bursts while negotiating
  localparam int unsigned BURST_GAP_CYCLES = 64;

  // register byte addresses
  localparam logic [7:0] ADDR_BASIC_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_ADVERT = 8'h04;
  localparam logic [7:0] ADDR_PARTNER = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_PAUSE = 8'h10;

  // basic control fields
  localparam int unsigned CTRL_DUPLEX_BIT = 8;
  localparam int unsigned CTRL_NEG_EN_BIT = 12;
  localparam int unsigned CTRL_SPEED_BIT = 13;
  localparam logic [15:0] CTRL_RESET = 16'h3100;

  // ability word fields
  localparam int unsigned ABIL_10HD = 5;
  localparam int unsigned ABIL_10FD = 6;
  localparam int unsigned ABIL_100HD = 7;
  localparam int unsigned ABIL_100FD = 8;
  localparam int unsigned ABIL_PAUSE = 10;
  localparam logic [15:0] ADVERT_RESET = 16'h05e1;

  // status fields
  localparam int unsigned STAT_NEG_DONE = 0;
  localparam int unsigned STAT_SPEED = 1;
  localparam int unsigned STAT_FULL = 2;
  localparam int unsigned STAT_FLOW_EN = 3;
  localparam int unsigned STAT_PAUSED = 4;
  localparam int unsigned STAT_NEG_RUN = 5;

  // control frame layout, byte positions from the first destination byte
  localparam logic [15:0] MAC_CTRL_TYPE = 16'h8808;
  localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
  localparam logic [4:0] POS_TYPE_HI = 5'h0c;
  localparam logic [4:0] POS_PARAM_LO = 5'h11;
  localparam logic [4:0] POS_MAX = 5'h1f;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } wb_req_type;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_type;

  typedef struct packed {
    logic valid;
    logic sof;
    logic eof;
    logic good;
    logic [7:0] data;
  } rx_byte_type;

  typedef struct packed {
    logic valid;
    logic [15:0] quanta;
  } pause_req_type;

  typedef enum logic [2:0] {
    NEG_OFF = 3'b001,
    NEG_RUN = 3'b010,
    NEG_DONE = 3'b100
  } neg_state_type;

endpackage

// ===== pause_frame_parser.sv
`timescale 1ns/1ps
module pause_frame_parser
  import duplex_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input rx_byte_type rx_i,
  output pause_req_type req_o
);

  typedef struct packed {
    logic [4:0] pos;      // index of the next byte, saturating
    logic [47:0] hdr;     // type, opcode and parameter bytes in order
    pause_req_type req;   // one-cycle pause request
  } parse_type;

  parse_type q, d;
  logic [4:0] p;          // position of the byte now arriving

  // collect bytes 12..17 and judge the frame at its last byte
  always_comb begin
    d = q;
    d.req.valid = 1'b0;
    p = rx_i.sof ? 5'h00 : q.pos;
    if (rx_i.valid) begin
      // control frames are told apart only by the type field
      if (p >= POS_TYPE_HI && p <= POS_PARAM_LO) begin
        d.hdr = {q.hdr[39:0], rx_i.data};
      end
      d.pos = (p == POS_MAX) ? POS_MAX : p + 5'h01;
      if (rx_i.eof && rx_i.good && p > POS_PARAM_LO) begin
        // the last captured bytes sit in the low half of the shifter
        if (q.hdr[47:32] == MAC_CTRL_TYPE && q.hdr[31:16] == PAUSE_OPCODE) begin
          d.req.valid = 1'b1;
          d.req.quanta = q.hdr[15:0]; // unsigned slot count
        end
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign req_o = q.req;

endmodule

// ===== duplex_pause_flow_control.sv
`timescale 1ns/1ps
// Overview of operation
// - full duplex: no collision, sense on receive
// - half duplex: no overlap, collision, sense both
// - control bit 12 turns negotiation on
// - bursts carry sixteen-bit advertised ability word
// - pick best common ability in fixed order
// - negotiate after reset or when enabled
// - negotiation off: speed, duplex from control
// - flow control only after full-duplex pause negotiation
// - control frame by type, pause opcode 0001h
// - pause length is unsigned two-octet slot count
// - timer loads, pauses, ends at zero
// - started transmission is never cut off
// - no new start after valid pause
// - zero pause ends pause state at once
module duplex_pause_flow_control
  import duplex_pkg::*;
#(
  parameter int unsigned SLOT10_CYCLES_P = SLOT10_CYCLES,
  parameter int unsigned BURST_GAP_P = BURST_GAP_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wb_req_type wb_i,
  output wb_rsp_type wb_o,
  input rx_byte_type rx_i,
  input wire logic phy_rx_active_i,
  input wire logic phy_tx_active_i,
  input wire logic phy_collision_i,
  input wire logic [15:0] partner_word_i,
  input wire logic partner_word_valid_i,
  output logic crs_o,
  output logic col_o,
  output logic tx_start_ok_o,
  output logic burst_start_o,
  output logic [15:0] burst_word_o,
  output logic speed100_o,
  output logic full_duplex_o,
  output logic paused_o
);

  typedef struct packed {
    logic [15:0] ctrl;        // transceiver_basic_control
    logic [15:0] advert;      // ability_advert_register
    logic [15:0] partner;     // partner_ability_config
    neg_state_type neg;       // negotiation state
    logic [15:0] gap_cnt;     // cycles since the last burst
    logic burst_start;        // one-cycle burst strobe
    logic [15:0] bword;       // word carried by the burst
    logic speed100;           // current speed
    logic full;               // current duplex
    logic flow_en;            // pause handling allowed
    logic paused;             // transmit held off
    logic [15:0] pause_cnt;   // remaining slot times
    logic [13:0] slot_cnt;    // cycles within the current slot
    logic crs;                // carrier sense
    logic col;                // collision
    logic tx_ok;              // a new frame may start
    logic ack;                // bus acknowledge
    logic [31:0] rdat;        // bus read data
  } st_type;

  st_type q, d;
  pause_req_type pr;          // request from the frame parser
  logic [2:0] res;            // {valid, speed100, full}
  logic [13:0] slot_limit;    // last cycle of a slot

  // frame decoder for received control frames
  pause_frame_parser u_parser (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .rx_i(rx_i),
    .req_o(pr)
  );

  // best common mode, highest first
  function automatic logic [2:0] resolve(input logic [15:0] a,
                                         input logic [15:0] b);
    logic [15:0] c;
    c = a & b;
    if (c[ABIL_100FD]) resolve = 3'b111;
    else if (c[ABIL_100HD]) resolve = 3'b110;
    else if (c[ABIL_10FD]) resolve = 3'b101;
    else if (c[ABIL_10HD]) resolve = 3'b100;
    else resolve = 3'b000;
  endfunction

  // byte-lane merge of a sixteen-bit register write
  function automatic logic [15:0] wr16(input logic [15:0] old,
                                       input logic [31:0] dat,
                                       input logic [3:0] sel);
    wr16 = old;
    if (sel[0]) wr16[7:0] = dat[7:0];
    if (sel[1]) wr16[15:8] = dat[15:8];
  endfunction

  // slot length follows the speed in use
  assign slot_limit = q.speed100 ? 14'(SLOT100_CYCLES - 1)
                                 : 14'(SLOT10_CYCLES_P - 1);
  assign res = resolve(q.advert, partner_word_i);

  // next-state logic for bus, negotiation, pause and carrier
  always_comb begin
    d = q;
    d.ack = 1'b0;
    d.burst_start = 1'b0;

    // wishbone slave, one wait state, ack for one cycle
    if (wb_i.cyc && wb_i.stb && !q.ack) begin
      d.ack = 1'b1;
      d.rdat = 32'h00000000;
      unique case (wb_i.adr)
        ADDR_BASIC_CONTROL: begin
          d.rdat[15:0] = q.ctrl;
          if (wb_i.we) d.ctrl = wr16(q.ctrl, wb_i.dat, wb_i.sel);
        end
        ADDR_ADVERT: begin
          d.rdat[15:0] = q.advert;
          if (wb_i.we) d.advert = wr16(q.advert, wb_i.dat, wb_i.sel);
        end
        ADDR_PARTNER: begin
          d.rdat[15:0] = q.partner;
        end
        ADDR_STATUS: begin
          d.rdat[STAT_NEG_DONE] = (q.neg == NEG_DONE);
          d.rdat[STAT_SPEED] = q.speed100;
          d.rdat[STAT_FULL] = q.full;
          d.rdat[STAT_FLOW_EN] = q.flow_en;
          d.rdat[STAT_PAUSED] = q.paused;
          d.rdat[STAT_NEG_RUN] = (q.neg == NEG_RUN);
        end
        ADDR_PAUSE: begin
          d.rdat[15:0] = q.pause_cnt;
        end
        default: begin
          // unmapped: acknowledged, reads zero, writes dropped
        end
      endcase
    end

    // negotiation sequencer, steered by the enable bit
    unique case (q.neg)
      NEG_OFF: begin
        // manual speed and duplex while negotiation is off
        d.speed100 = q.ctrl[CTRL_SPEED_BIT];
        d.full = q.ctrl[CTRL_DUPLEX_BIT];
        if (q.ctrl[CTRL_NEG_EN_BIT]) begin
          d.neg = NEG_RUN;
          d.gap_cnt = 16'h0000;
          d.burst_start = 1'b1;
          d.bword = q.advert;
        end
      end
      NEG_RUN: begin
        if (!q.ctrl[CTRL_NEG_EN_BIT]) begin
          d.neg = NEG_OFF;
        end else begin
          // repeat bursts until the partner answers with a common mode
          if (q.gap_cnt == 16'(BURST_GAP_P - 1)) begin
            d.gap_cnt = 16'h0000;
            d.burst_start = 1'b1;
            d.bword = q.advert;
          end else begin
            d.gap_cnt = q.gap_cnt + 16'h0001;
          end
          if (partner_word_valid_i) begin
            d.partner = partner_word_i;
            if (res[2]) begin
              d.neg = NEG_DONE;
              d.speed100 = res[1];
              d.full = res[0];
            end
          end
        end
      end
      NEG_DONE: begin
        if (!q.ctrl[CTRL_NEG_EN_BIT]) d.neg = NEG_OFF;
      end
    endcase

    // pause only after full-duplex pause negotiation
    d.flow_en = (q.neg == NEG_DONE) && q.full &&
                q.advert[ABIL_PAUSE] && q.partner[ABIL_PAUSE];

    // count slots down while paused
    if (q.paused) begin
      if (q.slot_cnt == slot_limit) begin
        d.slot_cnt = 14'h0000;
        d.pause_cnt = q.pause_cnt - 16'h0001;
        if (q.pause_cnt == 16'h0001) d.paused = 1'b0;
      end else begin
        d.slot_cnt = q.slot_cnt + 14'h0001;
      end
    end

    // a new request overrides the running count
    if (!q.flow_en || !q.full) begin
      d.paused = 1'b0; // requests fall through unused
      d.pause_cnt = 16'h0000;
    end else if (pr.valid) begin
      if (pr.quanta == 16'h0000) begin
        d.paused = 1'b0;
        d.pause_cnt = 16'h0000;
      end else begin
        d.paused = 1'b1;
        d.pause_cnt = pr.quanta;
        d.slot_cnt = 14'h0000;
      end
    end

    // carrier and collision by duplex
    if (q.full) begin
      d.crs = phy_rx_active_i;
      d.col = 1'b0;
    end else begin
      d.crs = phy_rx_active_i || phy_tx_active_i;
      // a line collision or our own overlap both count
      d.col = phy_collision_i ||
              (phy_rx_active_i && phy_tx_active_i);
    end

    // gates only the start, a frame under way runs on
    // next pause state is used so the hold-off is immediate
    d.tx_ok = !d.paused && (q.full || !phy_rx_active_i);
  end

  // state register
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
      q.ctrl <= CTRL_RESET;
      q.advert <= ADVERT_RESET;
      q.neg <= NEG_OFF;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign wb_o.ack = q.ack;
  assign wb_o.dat = q.rdat;
  assign crs_o = q.crs;
  assign col_o = q.col;
  assign tx_start_ok_o = q.tx_ok;
  assign burst_start_o = q.burst_start;
  assign burst_word_o = q.bword;
  assign speed100_o = q.speed100;
  assign full_duplex_o = q.full;
  assign paused_o = q.paused;

  // checks on the behaviour above
  AST_FD_NO_COL: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    q.full |=> !q.col)
    else $error("collision shown in full duplex");
  AST_FD_CRS: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    q.full |=> (q.crs == $past(phy_rx_active_i)))
    else $error("full duplex carrier not tied to receive");
  AST_HD_CRS: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    !q.full && (phy_tx_active_i || phy_rx_active_i) |=> q.crs)
    else $error("half duplex carrier missing");
  AST_HD_COL: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    !q.full && phy_rx_active_i && phy_tx_active_i |=> q.col)
    else $error("half duplex overlap not shown as collision");
  AST_HD_NO_OVERLAP: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    !q.full && phy_rx_active_i |=> !q.tx_ok)
    else $error("start allowed while receiving in half duplex");
  AST_NEG_START: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (q.neg == NEG_OFF) && q.ctrl[CTRL_NEG_EN_BIT] |=>
      q.burst_start && (q.neg == NEG_RUN))
    else $error("negotiation did not start");
  AST_BURST_WORD: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    $rose(q.burst_start) |-> (q.bword == $past(q.advert)))
    else $error("burst word differs from advertisement");
  AST_MANUAL: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (q.neg == NEG_OFF) |=>
      (q.speed100 == $past(q.ctrl[CTRL_SPEED_BIT])) &&
      (q.full == $past(q.ctrl[CTRL_DUPLEX_BIT])))
    else $error("manual speed or duplex not applied");
  AST_RESOLVE: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (q.neg == NEG_RUN) && q.ctrl[CTRL_NEG_EN_BIT] &&
      partner_word_valid_i && q.advert[ABIL_100FD] &&
      partner_word_i[ABIL_100FD] |=> q.speed100 && q.full)
    else $error("best common mode not chosen");
  AST_FLOW_EN: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    q.flow_en |-> $past(q.neg == NEG_DONE) && $past(q.full))
    else $error("flow control enabled without full duplex negotiation");
  AST_PAUSE_LOAD: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    pr.valid && q.flow_en && q.full && (pr.quanta != 16'h0000) |=>
      q.paused && !q.tx_ok && (q.pause_cnt == $past(pr.quanta)))
    else $error("pause request not taken at once");
  AST_PAUSE_ZERO: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    pr.valid && q.flow_en && q.full && (pr.quanta == 16'h0000) |=>
      !q.paused)
    else $error("zero pause did not release");
  AST_PAUSE_HOLD: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    q.paused && q.flow_en && q.full && !pr.valid &&
      (q.pause_cnt > 16'h0001) |=> q.paused)
    else $error("pause left before the count ran out");
  AST_PAUSE_END: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    q.paused && q.flow_en && q.full && !pr.valid &&
      (q.pause_cnt == 16'h0001) && (q.slot_cnt == slot_limit) |=>
      !q.paused && q.tx_ok)
    else $error("pause not left when the count ran out");
  AST_SLOT_TICK: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    q.paused && q.flow_en && q.full && !pr.valid &&
      (q.slot_cnt == slot_limit) |=>
      (q.pause_cnt == $past(q.pause_cnt) - 16'h0001))
    else $error("pause count did not step at slot end");
  AST_IGNORE: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    pr.valid && !q.flow_en |=> !q.paused)
    else $error("pause taken without flow control");
  AST_WB_ACK: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    wb_i.cyc && wb_i.stb && !q.ack |=> q.ack ##1 !q.ack)
    else $error("bus acknowledge not one cycle");

endmodule

// ===== duplex_partner_model.sv
`timescale 1ns/1ps
// link partner: answers link pulse bursts and sends control frames
module duplex_partner_model
  import duplex_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic burst_start_i,
  input wire logic [15:0] ability_i,
  input wire logic [3:0] delay_i,
  input wire logic send_i,
  input wire logic [15:0] opcode_i,
  input wire logic [15:0] quanta_i,
  output rx_byte_type rx_o,
  output logic [15:0] word_o,
  output logic word_valid_o
);
  logic [7:0] frame_q [20]; // bytes of the frame being sent
  logic [5:0] idx_q; // next byte index, 20 when idle
  logic [4:0] wait_q; // cycles left before the ability answer

  // answers a burst with its own ability word, promptly or slowly
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_q <= '0;
      word_valid_o <= 1'b0;
      word_o <= '0;
    end else begin
      word_valid_o <= 1'b0;
      if (word_valid_o) begin
        word_o <= ~word_o; // stale word is not kept on the line
      end
      if (burst_start_i && wait_q == 5'h00) begin
        wait_q <= {1'b0, delay_i} + 5'h01;
      end else if (wait_q == 5'h01) begin
        word_valid_o <= 1'b1;
        word_o <= ability_i;
        wait_q <= '0;
      end else if (wait_q != 5'h00) begin
        wait_q <= wait_q - 5'h01;
      end
    end
  end

  // sends one control frame, a byte a cycle, after a send request
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      idx_q <= 6'h14;
      rx_o <= '0;
    end else if (send_i) begin
      // reserved multicast destination, then source, type, body
      frame_q <= '{8'h01, 8'h80, 8'hc2, 8'h00, 8'h00, 8'h01,
        8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02,
        MAC_CTRL_TYPE[15:8], MAC_CTRL_TYPE[7:0],
        opcode_i[15:8], opcode_i[7:0], quanta_i[15:8], quanta_i[7:0],
        8'h00, 8'h00};
      idx_q <= 6'h00;
    end else if (idx_q < 6'h14) begin
      rx_o.valid <= 1'b1;
      rx_o.sof <= (idx_q == 6'h00);
      rx_o.eof <= (idx_q == 6'h13);
      rx_o.good <= (idx_q == 6'h13);
      rx_o.data <= frame_q[idx_q[4:0]];
      idx_q <= idx_q + 6'h01;
    end else begin
      // between frames the data line changes every cycle
      rx_o.valid <= 1'b0;
      rx_o.sof <= 1'b0;
      rx_o.eof <= 1'b0;
      rx_o.good <= 1'b0;
      rx_o.data <= ~rx_o.data;
    end
  end
endmodule

// ===== duplex_pause_flow_control_tb_top.sv
`timescale 1ns/1ps
// compares two values and counts the comparison
`define CHK(name, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("ERROR %s expected %h seen %h", name, exp, got); \
    end \
  end
module duplex_pause_flow_control_tb_top
  import duplex_pkg::*;
;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  wb_req_type wb_req = '0;
  wb_rsp_type wb_rsp;
  rx_byte_type rx;
  logic rx_act = 1'b0;
  logic tx_act = 1'b0;
  logic col_in = 1'b0;
  logic [15:0] pword;
  logic pvalid;
  logic crs, col, tx_ok, burst, s100, fd, paused;
  logic [15:0] bword;
  logic [15:0] ability = 16'h05e1; // partner ability word
  logic [3:0] dly = 4'h0; // partner answer delay
  logic send = 1'b0;
  logic [15:0] opcode = 16'h0001;
  logic [15:0] quanta = 16'h0000;
  logic [31:0] rdq [$]; // expected read data, oldest first
  logic [31:0] exp_rd;

  always #2.5 clk = ~clk;

  duplex_pause_flow_control #(.SLOT10_CYCLES_P(16), .BURST_GAP_P(4)) dut (
    .ref_clk_i(clk), .rstn_i(rstn), .wb_i(wb_req), .wb_o(wb_rsp),
    .rx_i(rx), .phy_rx_active_i(rx_act), .phy_tx_active_i(tx_act),
    .phy_collision_i(col_in), .partner_word_i(pword),
    .partner_word_valid_i(pvalid), .crs_o(crs), .col_o(col),
    .tx_start_ok_o(tx_ok), .burst_start_o(burst), .burst_word_o(bword),
    .speed100_o(s100), .full_duplex_o(fd), .paused_o(paused));

  duplex_partner_model partner (
    .ref_clk_i(clk), .rstn_i(rstn), .burst_start_i(burst),
    .ability_i(ability), .delay_i(dly), .send_i(send), .opcode_i(opcode),
    .quanta_i(quanta), .rx_o(rx), .word_o(pword), .word_valid_o(pvalid));

  // prints the counts and the verdict, then ends the run
  task test_done();
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // cuts a hung run short
  always @(posedge clk) begin
    cycles++;
    if (cycles > 40000) begin
      n_errors++;
      test_done();
    end
  end

  // takes the oldest expected value whenever read data comes back
  always @(posedge clk) begin
    if (wb_rsp.ack === 1'b1 && wb_req.we === 1'b0) begin
      exp_rd = rdq.pop_front();
      `CHK("read data", exp_rd, wb_rsp.dat)
    end
  end

  // one classic bus cycle, held until ack is sampled high
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'h3, adr: a, dat: d};
    do @(posedge clk); while (wb_rsp.ack !== 1'b1);
    wb_req <= '0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    rdq.push_back(e);
    wb(1'b0, a, 32'h0000_0000);
  endtask

  // expected {speed100, full} in the fixed priority order
  function logic [1:0] resolve(input logic [15:0] c);
    return c[ABIL_100FD] ? 2'b11 : c[ABIL_100HD] ? 2'b10 :
      c[ABIL_10FD] ? 2'b01 : 2'b00;
  endfunction

  // waits for a burst and the partner answer, then checks the mode
  task wait_neg(input logic [1:0] m);
    do @(posedge clk); while (burst !== 1'b1);
    `CHK("burst word", ADVERT_RESET, bword)
    do @(posedge clk); while (pvalid !== 1'b1);
    repeat (2) @(posedge clk);
    `CHK("speed", m[1], s100)
    `CHK("duplex", m[0], fd)
  endtask

  task negotiate(input logic [15:0] ab);
    ability <= ab;
    dly <= 4'($urandom_range(0, 12));
    wb(1'b1, ADDR_BASIC_CONTROL, 32'h0000_2100);
    // let a late answer from the partner drain first
    repeat (16) @(posedge clk);
    wb(1'b1, ADDR_BASIC_CONTROL, 32'h0000_3100);
    wait_neg(resolve(ab & ADVERT_RESET));
  endtask

  // walks every carrier input combination
  task carrier(input logic full);
    int i;
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      {col_in, tx_act, rx_act} <= 3'(i);
      repeat (2) @(posedge clk);
      `CHK("crs", full ? rx_act : rx_act | tx_act, crs)
      `CHK("col", full ? 1'b0 : col_in | tx_act & rx_act, col)
      `CHK("tx ok", full | ~rx_act, tx_ok)
    end
    {col_in, tx_act, rx_act} <= 3'h0;
  endtask

  task send_pause(input logic [15:0] op, input logic [15:0] q,
                  input logic e);
    @(posedge clk);
    opcode <= op;
    quanta <= q;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    do @(posedge clk); while (rx.eof !== 1'b1);
    repeat (3) @(posedge clk);
    `CHK("paused", e, paused)
    `CHK("tx start", ~e, tx_ok)
  endtask

  task count_pause(input int e);
    int n;
    n = 0;
    while (paused === 1'b1 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    `CHK("pause length", 1'b1, n >= e - 3 && n <= e + 2)
    @(posedge clk);
    `CHK("resume", 1'b1, tx_ok)
  endtask

  // main sequence
  initial begin
    void'($urandom(32'h8df9));
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    wait_neg(2'b11);
    rd(ADDR_BASIC_CONTROL, 32'h0000_3100);
    rd(ADDR_ADVERT, 32'h0000_05e1);
    rd(ADDR_STATUS, 32'h0000_000f);
    wb(1'b1, ADDR_STATUS, 32'h0000_0000);
    rd(ADDR_STATUS, 32'h0000_000f);
    wb(1'b1, 8'h1c, 32'h0000_ffff);
    rd(8'h1c, 32'h0000_0000);
    carrier(1'b1);
    send_pause(PAUSE_OPCODE, 16'h0002, 1'b1);
    count_pause(2 * 1024);
    send_pause(16'h0002, 16'h0005, 1'b0);
    send_pause(PAUSE_OPCODE, 16'hffff, 1'b1);
    send_pause(PAUSE_OPCODE, 16'h0000, 1'b0);
    wb(1'b1, ADDR_BASIC_CONTROL, 32'h0000_2100);
    repeat (3) @(posedge clk);
    `CHK("manual speed", 1'b1, s100)
    `CHK("manual duplex", 1'b1, fd)
    send_pause(PAUSE_OPCODE, 16'h0005, 1'b0);
    wb(1'b1, ADDR_BASIC_CONTROL, 32'h0000_0000);
    repeat (3) @(posedge clk);
    `CHK("manual speed", 1'b0, s100)
    `CHK("manual duplex", 1'b0, fd)
    carrier(1'b0);
    repeat (5) negotiate((16'($urandom) & 16'h05e0) | 16'h0020);
    negotiate(16'h0440);
    send_pause(PAUSE_OPCODE, 16'h0003, 1'b1);
    count_pause(3 * 16);
    negotiate(16'h0420);
    send_pause(PAUSE_OPCODE, 16'h0003, 1'b0);
    test_done();
  end
endmodule
